// ### logic/twec_regs.svh
// Purpose: Shared constants of the trigger window and edge configuration link.
// Assumes: Opcodes sit in the upper byte of each 16-bit command word.
// Notes:   Definitions only; included by the package, the checker and the bench.
`ifndef TWEC_REGS_SVH
`define TWEC_REGS_SVH

// Opcodes, upper byte of the command word.
`define TWEC_OP_TRIG_MODE  8'h00
`define TWEC_OP_CONT_MODE  8'h01
`define TWEC_OP_SET_WIDTH  8'h10
`define TWEC_OP_SET_OFFSET 8'h11
`define TWEC_OP_SET_SEARCH 8'h12
`define TWEC_OP_SET_REJECT 8'h13
`define TWEC_OP_SUB_ON     8'h14
`define TWEC_OP_SUB_OFF    8'h15
`define TWEC_OP_READ_TRIG  8'h16
`define TWEC_OP_SET_EDGE   8'h22
`define TWEC_OP_READ_EDGE  8'h23
`define TWEC_OP_SET_LSB    8'h24
`define TWEC_OP_SET_PAIR   8'h25
`define TWEC_OP_READ_RES   8'h26

// Field positions inside a 16-bit word.
`define TWEC_OPCODE_LSB     8
`define TWEC_PAIR_LEAD_LSB  0
`define TWEC_PAIR_WIDTH_LSB 8

// Reset values of the configuration, then the pair edge mode code.
`define TWEC_DEF_WIDTH      12'h014
`define TWEC_DEF_OFFSET     12'hfd8
`define TWEC_DEF_SEARCH     12'h008
`define TWEC_DEF_REJECT     12'h004
`define TWEC_DEF_EDGE       2'b11
`define TWEC_DEF_LSB        2'b11
`define TWEC_DEF_PAIR_LEAD  3'h0
`define TWEC_DEF_PAIR_WIDTH 4'h0
`define TWEC_EDGE_PAIR      2'b00

// Word counts and timing.
`define TWEC_TRIG_READ_WORDS 3'd5
`define TWEC_ONE_READ_WORD   3'd1
`define TWEC_CLK_PERIOD_NS   25

// Window offset limits as 12-bit signed codes.
`define TWEC_OFFSET_MAX 12'h028
`define TWEC_OFFSET_MIN 12'h800

// Host APB register offsets.
`define TWEC_HOST_WORD_OUT 8'h00
`define TWEC_HOST_WORD_IN  8'h04
`define TWEC_HOST_STATUS   8'h08
`define TWEC_HOST_CTRL     8'h0c

`endif

// ### logic/twec_pkg.sv
// Purpose: Types and opcode decoding shared by both ends of the link.
// Assumes: Constants come from twec_regs.svh.
// Notes:   The decode functions keep both ends in step on word counts.
`include "twec_regs.svh"
package twec_pkg;

	typedef enum logic [2:0]
	{
		TWEC_IDLE  = 3'b001,
		TWEC_PARAM = 3'b010,
		TWEC_REPLY = 3'b100
	} twec_dev_state_e;

	typedef logic [1:0] twec_edge_t;

	// True for opcodes that are followed by one parameter word.
	function automatic logic twec_is_set_op(input logic [7:0] op);
		case (op)
			`TWEC_OP_SET_WIDTH, `TWEC_OP_SET_OFFSET, `TWEC_OP_SET_SEARCH,
			`TWEC_OP_SET_REJECT, `TWEC_OP_SET_EDGE, `TWEC_OP_SET_LSB,
			`TWEC_OP_SET_PAIR: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : twec_is_set_op

	// Number of words the host must read back after an opcode.
	function automatic logic [2:0] twec_read_count(input logic [7:0] op);
		case (op)
			`TWEC_OP_READ_TRIG: return `TWEC_TRIG_READ_WORDS;
			`TWEC_OP_READ_EDGE, `TWEC_OP_READ_RES: return `TWEC_ONE_READ_WORD;
			default: return 3'd0;
		endcase
	endfunction : twec_read_count

endpackage : twec_pkg

// ### logic/twec_link_if.sv
// Purpose: Word link between the configuration host and the device end.
// Assumes: Both ends share core_clk; all signals change after a rising edge.
// Notes:   A write moves on wrValid and wrReady high together; a read on rdTake.
`timescale 1ns/10ps
`default_nettype none
interface twec_link_if;
	logic        wrValid;
	logic [15:0] wrData;
	logic        wrReady;
	logic        rdValid;
	logic [15:0] rdData;
	logic        rdTake;

	modport dev
	(
		input  wrValid,
		input  wrData,
		input  rdTake,
		output wrReady,
		output rdValid,
		output rdData
	);

	modport host
	(
		output wrValid,
		output wrData,
		output rdTake,
		input  wrReady,
		input  rdValid,
		input  rdData
	);
endinterface : twec_link_if
`default_nettype wire

// ### logic/twec_cfg_bank.sv
// Purpose: Configuration store of the device end.
// Assumes: Strobes are one-cycle pulses from the device command sequencer.
// Notes:   Every output is a flip-flop; unused word bits are dropped here.
`timescale 1ns/10ps
`default_nettype none
module twec_cfg_bank
(
	input  wire logic                core_clk,
	input  wire logic                srst,
	input  wire logic                opStrobe,
	input  wire logic                paramStrobe,
	input  wire logic [7:0]          opcode,
	input  wire logic [15:0]         word,
	output logic      [11:0]         windowWidth,
	output logic      [11:0]         windowOffset,
	output logic      [11:0]         searchMargin,
	output logic      [11:0]         rejectMargin,
	output logic                     subtractEn,
	output logic                     autoRejectEn,
	output twec_pkg::twec_edge_t     edgeMode,
	output logic      [1:0]          lsbCode,
	output logic      [2:0]          pairLeadRes,
	output logic      [3:0]          pairWidthRes
);
	import twec_pkg::*;

	// Immediate opcodes act on opStrobe, parameter words on paramStrobe.
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			windowWidth  <= `TWEC_DEF_WIDTH;
			windowOffset <= `TWEC_DEF_OFFSET;
			searchMargin <= `TWEC_DEF_SEARCH;
			rejectMargin <= `TWEC_DEF_REJECT;
			subtractEn   <= 1'b0;
			autoRejectEn <= 1'b0;
			edgeMode     <= `TWEC_DEF_EDGE;
			lsbCode      <= `TWEC_DEF_LSB;
			pairLeadRes  <= `TWEC_DEF_PAIR_LEAD;
			pairWidthRes <= `TWEC_DEF_PAIR_WIDTH;
		end
		else
		begin
			if (opStrobe)
			begin
				case (opcode)
					`TWEC_OP_SUB_ON:    subtractEn <= 1'b1;
					`TWEC_OP_SUB_OFF:   subtractEn <= 1'b0;
					`TWEC_OP_TRIG_MODE: autoRejectEn <= 1'b1;
					`TWEC_OP_CONT_MODE:
					begin
						subtractEn   <= 1'b0;
						autoRejectEn <= 1'b0;
					end
					default: ;
				endcase
			end
			if (paramStrobe)
			begin
				case (opcode)
					`TWEC_OP_SET_WIDTH:  windowWidth  <= word[11:0];
					`TWEC_OP_SET_OFFSET: windowOffset <= word[11:0];
					`TWEC_OP_SET_SEARCH: searchMargin <= word[11:0];
					`TWEC_OP_SET_REJECT: rejectMargin <= word[11:0];
					`TWEC_OP_SET_EDGE:   edgeMode     <= word[1:0];
					`TWEC_OP_SET_LSB:    lsbCode      <= word[1:0];
					`TWEC_OP_SET_PAIR:
					begin
						pairLeadRes  <= word[`TWEC_PAIR_LEAD_LSB +: 3];
						pairWidthRes <= word[`TWEC_PAIR_WIDTH_LSB +: 4];
					end
					default: ;
				endcase
			end
		end
	end
endmodule : twec_cfg_bank
`default_nettype wire

// ### logic/twec_dev_end.sv
// Purpose: Device end of the trigger window and edge configuration link.
// Assumes: The host follows each opcode with the words that opcode needs.
// Notes:   Sequencer stalls in a wait state exactly like the board controller.
//
// Operation
// - Set opcode takes exactly one parameter word.
// - Single read opcode holds word until read.
// - Width from bits 11:0, default 0x14.
// - Offset is 12-bit signed, host sign-extends.
// - Host keeps offset in range; default 0xFFD8.
// - Offset aligned to whole clock cycles.
// - Extra search margin from low 12 bits.
// - Reject margin from low 12 bits, default 4.
// - Opcode 14 enables trigger time subtraction.
// - Opcode 15 disables trigger time subtraction.
// - Opcode 16 needs five reads before continuing.
// - Readback: width, offset, search, reject, subtract.
// - Edge detection from two low bits.
// - Host picks pair mode only in low resolution.
// - Opcode 23 reads back edge setting.
// - Leading/trailing LSB from bits 1:0.
// - Pair resolutions from bits 2:0 and 11:8.
// - Host sets pair resolution only after pair; host sends it anyway and sets orderWarn.
// - Opcode 26 reads resolution per edge mode.
// - Continuous mode clears subtraction and auto reject.
`timescale 1ns/10ps
`default_nettype none
module twec_dev_end
(
	input  wire logic                core_clk,
	input  wire logic                srst,
	twec_link_if.dev                 link,
	output logic                     busy,
	output logic      [11:0]         windowWidth,
	output logic      [11:0]         windowOffset,
	output logic      [11:0]         searchMargin,
	output logic      [11:0]         rejectMargin,
	output logic                     subtractEn,
	output logic                     autoRejectEn,
	output twec_pkg::twec_edge_t     edgeMode,
	output logic      [1:0]          lsbCode,
	output logic      [2:0]          pairLeadRes,
	output logic      [3:0]          pairWidthRes
);
	import twec_pkg::*;

	twec_dev_state_e state;
	logic [7:0]      pendOp;
	logic [2:0]      replyIdx;
	logic [2:0]      replyLast;
	logic            wrReady;
	logic            rdValid;
	logic [15:0]     rdData;

	// Link outputs come straight from the sequencer flip-flops.
	assign link.wrReady = wrReady;
	assign link.rdValid = rdValid;
	assign link.rdData  = rdData;

	// Handshake decode.
	wire        wordIn     = link.wrValid & wrReady;
	wire        wordTaken  = link.rdTake & rdValid;
	wire [7:0]  inOpcode   = link.wrData[15:`TWEC_OPCODE_LSB];
	wire        inIsSet    = twec_is_set_op(inOpcode);
	wire [2:0]  inReadCnt  = twec_read_count(inOpcode);
	wire        inIsRead   = (inReadCnt != 3'd0);
	wire        inIdle     = (state == TWEC_IDLE);
	wire        inParam    = (state == TWEC_PARAM);
	wire        inReply    = (state == TWEC_REPLY);

	// Strobes into the configuration store. Immediate opcodes act at once;
	// the store sees a parameter word only in the parameter wait state.
	wire        opStrobe    = wordIn & inIdle & ~inIsSet & ~inIsRead;
	wire        paramStrobe = wordIn & inParam;
	wire [7:0]  bankOp      = inParam ? pendOp : inOpcode;

	twec_cfg_bank u_bank
	(
		.core_clk     (core_clk),
		.srst         (srst),
		.opStrobe     (opStrobe),
		.paramStrobe  (paramStrobe),
		.opcode       (bankOp),
		.word         (link.wrData),
		.windowWidth  (windowWidth),
		.windowOffset (windowOffset),
		.searchMargin (searchMargin),
		.rejectMargin (rejectMargin),
		.subtractEn   (subtractEn),
		.autoRejectEn (autoRejectEn),
		.edgeMode     (edgeMode),
		.lsbCode      (lsbCode),
		.pairLeadRes  (pairLeadRes),
		.pairWidthRes (pairWidthRes)
	);

	// Readback words. The offset is shown sign-extended so that the host
	// reads the same 16-bit form it was asked to write.
	wire [15:0] wWidth  = {4'h0, windowWidth};
	wire [15:0] wOffset = {{4{windowOffset[11]}}, windowOffset};
	wire [15:0] wSearch = {4'h0, searchMargin};
	wire [15:0] wReject = {4'h0, rejectMargin};
	wire [15:0] wSub    = {15'h0, subtractEn};
	wire [15:0] wEdge   = {14'h0, edgeMode};
	wire [15:0] wPair   = {4'h0, pairWidthRes, 5'h00, pairLeadRes};
	wire [15:0] wLsb    = {14'h0, lsbCode};
	wire        pairOn  = (edgeMode == `TWEC_EDGE_PAIR);
	wire [15:0] wRes    = pairOn ? wPair : wLsb;

	// Which word is due next: the first one when the opcode arrives, the
	// following one when the host takes a word in the reply state.
	wire [7:0]  selOp   = inIdle ? inOpcode : pendOp;
	wire [2:0]  selIdx  = inIdle ? 3'd0 : replyIdx;
	wire [15:0] wTrig   = (selIdx == 3'd0) ? wWidth  :
	                      (selIdx == 3'd1) ? wOffset :
	                      (selIdx == 3'd2) ? wSearch :
	                      (selIdx == 3'd3) ? wReject : wSub;
	wire [15:0] replyWord = (selOp == `TWEC_OP_READ_TRIG) ? wTrig :
	                        (selOp == `TWEC_OP_READ_EDGE) ? wEdge : wRes;
	wire        lastTaken = wordTaken & (replyIdx == replyLast);

	// Next state of the command sequencer.
	twec_dev_state_e next_state;
	always_comb
	begin
		next_state = state;
		case (state)
			TWEC_IDLE:
			begin
				if (wordIn & inIsSet)
					next_state = TWEC_PARAM;
				else if (wordIn & inIsRead)
					next_state = TWEC_REPLY;
			end
			TWEC_PARAM:
			begin
				if (wordIn)
					next_state = TWEC_IDLE;
			end
			TWEC_REPLY:
			begin
				if (lastTaken)
					next_state = TWEC_IDLE;
			end
			default: next_state = TWEC_IDLE;
		endcase
	end

	// Writes are refused while a reply is pending, so the host cannot slip a
	// new opcode in before the last word of a readback has been taken.
	wire next_wrReady = (next_state != TWEC_REPLY);
	wire next_busy    = (next_state != TWEC_IDLE);

	// State, the wrReady handshake flag and the busy flag.
	// The busy flag follows the wait state, so software can see a stall
	// without having to touch the link itself.
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			state   <= TWEC_IDLE;
			wrReady <= 1'b1;
			busy    <= 1'b0;
		end
		else
		begin
			state   <= next_state;
			wrReady <= next_wrReady;
			busy    <= next_busy;
		end
	end

	// Reply data path: the word stands on rdData until the host takes it.
	// The first word is loaded at the edge that accepts the opcode, so rdValid
	// never rises without a word behind it. A later take loads the next word;
	// the last take empties the path instead, which is why that branch is
	// tested before the plain take.
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			rdValid   <= 1'b0;
			rdData    <= 16'h0000;
			pendOp    <= 8'h00;
			replyIdx  <= 3'd0;
			replyLast <= 3'd0;
		end
		else if (wordIn & inIdle)
		begin
			pendOp    <= inOpcode;
			replyIdx  <= 3'd1;
			replyLast <= inReadCnt;
			rdValid   <= inIsRead;
			rdData    <= inIsRead ? replyWord : 16'h0000;
		end
		else if (lastTaken)
		begin
			rdValid <= 1'b0;
			rdData  <= 16'h0000;
		end
		else if (wordTaken)
		begin
			rdData   <= replyWord;
			replyIdx <= replyIdx + 3'd1;
		end
	end

endmodule : twec_dev_end
`default_nettype wire

// ### logic/twec_host_end.sv
// Purpose: Host end: turns APB register accesses into link words.
// Assumes: Software writes opcodes and parameters to WORD_OUT, reads WORD_IN.
// Notes:   pready is held low until the link moves the word; writes during a readback get pslverr.
`timescale 1ns/10ps
`default_nettype none
module twec_host_end
(
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	twec_link_if.host        link
);
	import twec_pkg::*;

	logic        wrValid;
	logic [15:0] wrData;
	logic        rdTake;
	logic        needParam;
	logic [7:0]  paramOp;
	logic [2:0]  readsLeft;
	logic        pairSet;
	logic        lowRes;
	logic        pairRefused;
	logic        orderWarn;

	assign link.wrValid = wrValid;
	assign link.wrData  = wrData;
	assign link.rdTake  = rdTake;

	// APB decode; an access is served once, pready closes it.
	wire access  = psel & penable & ~pready;
	wire selOut  = (paddr == `TWEC_HOST_WORD_OUT);
	wire selIn   = (paddr == `TWEC_HOST_WORD_IN);
	wire selStat = (paddr == `TWEC_HOST_STATUS);
	wire selCtrl = (paddr == `TWEC_HOST_CTRL);
	wire [7:0] opOfWord = wrData[15:`TWEC_OPCODE_LSB];

	// Parameter shaping: offsets are sign-extended and clamped, pair mode is
	// replaced by both edges unless low resolution is declared.
	wire [11:0] offRaw   = pwdata[11:0];
	wire        offHigh  = $signed(offRaw) > $signed(`TWEC_OFFSET_MAX);
	wire [11:0] offSafe  = offHigh ? `TWEC_OFFSET_MAX : offRaw;
	wire        isOffset = needParam & (paramOp == `TWEC_OP_SET_OFFSET);
	wire        badPair  = needParam & (paramOp == `TWEC_OP_SET_EDGE) &
	                       (pwdata[1:0] == `TWEC_EDGE_PAIR) & ~lowRes;
	wire [15:0] sendWord = isOffset ? {{4{offSafe[11]}}, offSafe} :
	                       badPair  ? {pwdata[15:2], `TWEC_DEF_EDGE} :
	                       pwdata[15:0];
	wire [31:0] statWord = {24'h0, link.rdValid, link.wrReady, orderWarn,
	                        pairRefused, readsLeft, needParam};

	// APB slave and link sequencing in one place, so the order of words on the
	// link always matches the order of accesses.
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			prdata <= 32'h0; pready <= 1'b0; pslverr <= 1'b0;
			wrValid <= 1'b0; wrData <= 16'h0; rdTake <= 1'b0;
			needParam <= 1'b0; paramOp <= 8'h00; readsLeft <= 3'd0;
			pairSet <= 1'b0; lowRes <= 1'b0; pairRefused <= 1'b0; orderWarn <= 1'b0;
		end
		else
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			rdTake  <= 1'b0;
			prdata  <= 32'h0;
			if (access & selOut & pwrite)
			begin
				if (readsLeft != 3'd0)
				begin
					pready  <= 1'b1;
					pslverr <= 1'b1;
				end
				else if (!wrValid)
				begin
					wrValid <= 1'b1;
					wrData  <= sendWord;
					if (badPair)
						pairRefused <= 1'b1;
				end
				else if (link.wrReady)
				begin
					wrValid <= 1'b0;
					pready  <= 1'b1;
					if (needParam)
					begin
						needParam <= 1'b0;
						if (paramOp == `TWEC_OP_SET_EDGE)
							pairSet <= (wrData[1:0] == `TWEC_EDGE_PAIR);
					end
					else
					begin
						needParam <= twec_is_set_op(opOfWord);
						paramOp   <= opOfWord;
						readsLeft <= twec_read_count(opOfWord);
						if ((opOfWord == `TWEC_OP_SET_PAIR) & ~pairSet)
							orderWarn <= 1'b1;
					end
				end
			end
			else if (access & selIn & ~pwrite)
			begin
				if (readsLeft == 3'd0)
				begin
					pready  <= 1'b1;
					pslverr <= 1'b1;
				end
				else if (link.rdValid & ~rdTake)
				begin
					rdTake    <= 1'b1;
					prdata    <= {16'h0, link.rdData};
					pready    <= 1'b1;
					readsLeft <= readsLeft - 3'd1;
				end
			end
			else if (access & selStat)
			begin
				pready <= 1'b1;
				prdata <= pwrite ? 32'h0 : statWord;
				if (pwrite & pwdata[4])
					pairRefused <= 1'b0;
				if (pwrite & pwdata[5])
					orderWarn <= 1'b0;
			end
			else if (access & selCtrl)
			begin
				pready <= 1'b1;
				prdata <= pwrite ? 32'h0 : {31'h0, lowRes};
				if (pwrite)
					lowRes <= pwdata[0];
			end
			else if (access)
			begin
				pready  <= 1'b1;
				pslverr <= 1'b1;
			end
		end
	end
endmodule : twec_host_end
`default_nettype wire

// ### verif/twec_props.sv
// Purpose: Checker for the word link between the host end and the device end.
// Assumes: All link signals change just after a rising edge of core_clk.
// Notes:   Helper logic tracks opcode versus parameter words independently.
`timescale 1ns/10ps
`default_nettype none
`include "twec_regs.svh"
module twec_props
(
	input wire logic        core_clk,
	input wire logic        srst,
	input wire logic        wrValid,
	input wire logic [15:0] wrData,
	input wire logic        wrReady,
	input wire logic        rdValid,
	input wire logic [15:0] rdData,
	input wire logic        rdTake
);
	logic       needParam;
	logic [2:0] pending;
	logic [7:0] lastOp;

	// Decode of the word offered on the link, with no help from the design.
	wire       accept   = wrValid && wrReady;
	wire [7:0] op       = wrData[15:8];
	wire       isOpcode = accept && !needParam;
	wire       isSet    = op inside {`TWEC_OP_SET_WIDTH, `TWEC_OP_SET_OFFSET, `TWEC_OP_SET_SEARCH,
		`TWEC_OP_SET_REJECT, `TWEC_OP_SET_EDGE, `TWEC_OP_SET_LSB, `TWEC_OP_SET_PAIR};
	wire [2:0] readCnt  = (op == `TWEC_OP_READ_TRIG) ? 3'd5 :
		((op == `TWEC_OP_READ_EDGE) || (op == `TWEC_OP_READ_RES)) ? 3'd1 : 3'd0;

	// A parameter word must never be mistaken for an opcode, so track which is due.
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			needParam <= 1'b0;
			pending   <= 3'd0;
			lastOp    <= 8'h00;
		end
		else
		begin
			if (isOpcode)
			begin
				needParam <= isSet;
				pending   <= readCnt;
				lastOp    <= op;
			end
			else if (accept)
				needParam <= 1'b0;
			if (rdTake && rdValid && (pending != 3'd0))
				pending <= pending - 3'd1;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	sequence trigReadTaken;
		isOpcode && (op == `TWEC_OP_READ_TRIG);
	endsequence
	sequence replyOpen;
		rdValid && !wrReady;
	endsequence

	reply_start_a: assert property (trigReadTaken |=> replyOpen)
		else $error("trigger readback did not open a reply");
	reply_count_a: assert property ((pending != 3'd0) == rdValid)
		else $error("reply words do not match the words owed");
	reply_hold_a: assert property (rdValid && !rdTake |=> rdValid && $stable(rdData))
		else $error("reply word changed before it was taken");
	writes_held_a: assert property (rdValid |-> !wrReady)
		else $error("writes accepted while a reply is owed");
	param_no_reply_a: assert property (accept && needParam |=> !rdValid && wrReady)
		else $error("parameter word handled as an opcode");
	last_word_a: assert property (rdValid && pending == 3'd1
		&& lastOp == `TWEC_OP_READ_TRIG |-> rdData[15:1] == 15'h0000)
		else $error("fifth readback word has stray bits");
	offset_sext_a: assert property (rdValid && pending == 3'd4
		&& lastOp == `TWEC_OP_READ_TRIG |-> rdData[15:12] == {4{rdData[11]}})
		else $error("offset word not sign extended");
	edge_word_a: assert property (rdValid && lastOp == `TWEC_OP_READ_EDGE
		|-> rdData[15:2] == 14'h0000)
		else $error("edge readback word has stray bits");
	reset_idle_a: assert property ($fell(srst) |-> wrReady && !rdValid)
		else $error("link not idle after reset");
endmodule : twec_props
`default_nettype wire

// ### verif/trigger_window_edge_config_opcodes_tb_top.sv
// Purpose: Self-checking bench joining host end and device end over the link.
// Assumes: Software view is the host APB map; expectations come from the rules.
// Notes:   Only the low 16 bits of read data are compared.
`timescale 1ns/10ps
`default_nettype none
`include "twec_regs.svh"
module trigger_window_edge_config_opcodes_tb_top;
	import twec_pkg::*;
	logic        core_clk = 1'b0;
	logic        srst     = 1'b1;
	logic [7:0]  paddr    = 8'h00;
	logic        psel     = 1'b0;
	logic        penable  = 1'b0;
	logic        pwrite   = 1'b0;
	logic [31:0] pwdata   = 32'h0;
	logic [31:0] prdata, lastRd;
	logic        pready, pslverr, lastErr, busy, subtractEn, autoRejectEn;
	logic [11:0] windowWidth, windowOffset, searchMargin, rejectMargin;
	twec_edge_t  edgeMode;
	logic [1:0]  lsbCode;
	logic [2:0]  pairLeadRes;
	logic [3:0]  pairWidthRes;
	int          n_errors = 0;
	int          n_compared = 0;
	int          cycles = 0;

	twec_link_if u_twec_link_if();
	twec_host_end u_twec_host_end (.core_clk(core_clk), .srst(srst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(u_twec_link_if));
	twec_dev_end u_twec_dev_end (.core_clk(core_clk), .srst(srst), .link(u_twec_link_if),
		.busy(busy), .windowWidth(windowWidth), .windowOffset(windowOffset),
		.searchMargin(searchMargin), .rejectMargin(rejectMargin), .subtractEn(subtractEn),
		.autoRejectEn(autoRejectEn), .edgeMode(edgeMode), .lsbCode(lsbCode),
		.pairLeadRes(pairLeadRes), .pairWidthRes(pairWidthRes));
	twec_props u_twec_props (.core_clk(core_clk), .srst(srst), .wrValid(u_twec_link_if.wrValid),
		.wrData(u_twec_link_if.wrData), .wrReady(u_twec_link_if.wrReady),
		.rdValid(u_twec_link_if.rdValid), .rdData(u_twec_link_if.rdData),
		.rdTake(u_twec_link_if.rdTake));

	// Clock at 40 MHz, and a watchdog so a stalled handshake cannot hang the run.
	always #12.5 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 8000)
		begin
			n_errors++;
			$display("Error at %0t: run did not finish in time", $time);
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop

	// One APB transfer; the request is held until pready is sampled high.
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge core_clk);
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		psel    <= 1'b1;
		penable <= 1'b0;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1)
			@(posedge core_clk);
		lastRd  = prdata;
		lastErr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic ck(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : ck

	task automatic wr(input logic [15:0] wd);
		apb(`TWEC_HOST_WORD_OUT, 1'b1, {16'h0000, wd});
	endtask : wr

	task automatic rdck(input logic [15:0] exp);
		apb(`TWEC_HOST_WORD_IN, 1'b0, 32'h0);
		ck(lastRd[15:0], exp);
	endtask : rdck

	task automatic set(input logic [7:0] op, input logic [15:0] p);
		wr({op, 8'h00});
		wr(p);
	endtask : set

	// The opcode carries a nonzero low byte, which the device must ignore.
	task automatic trig_ck(input logic [15:0] w0, w1, w2, w3, w4);
		wr({`TWEC_OP_READ_TRIG, 8'h5a});
		rdck(w0);
		rdck(w1);
		rdck(w2);
		rdck(w3);
		rdck(w4);
	endtask : trig_ck

	// Main sequence: reset, then one group of calls per behaviour.
	initial
	begin
		repeat (5) @(posedge core_clk);
		srst <= 1'b0;
		trig_ck(16'h0014, 16'hffd8, 16'h0008, 16'h0004, 16'h0000);
		ck({10'h0, edgeMode, 2'h0, lsbCode}, 16'h0033);
		$display("test defaults done");
		wr({`TWEC_OP_SET_WIDTH, 8'hab});
		apb(`TWEC_HOST_STATUS, 1'b0, 32'h0);
		ck({15'h0, lastRd[0]}, 16'h0001);
		ck({15'h0, busy}, 16'h0001);
		wr(16'hf123);
		set(`TWEC_OP_SET_OFFSET, 16'hfff6);
		set(`TWEC_OP_SET_SEARCH, 16'hf032);
		set(`TWEC_OP_SET_REJECT, 16'h0000);
		wr({`TWEC_OP_SUB_ON, 8'h00});
		trig_ck(16'h0123, 16'hfff6, 16'h0032, 16'h0000, 16'h0001);
		ck({4'h0, windowWidth}, 16'h0123);
		ck({4'h0, windowOffset}, 16'h0ff6);
		ck({4'h0, searchMargin}, 16'h0032);
		ck({4'h0, rejectMargin}, 16'h0000);
		// An offset above the upper limit must reach the device clamped.
		set(`TWEC_OP_SET_OFFSET, 16'h0031);
		set(`TWEC_OP_SET_WIDTH, 16'h1600);
		wr({`TWEC_OP_SUB_OFF, 8'h00});
		trig_ck(16'h0600, 16'h0028, 16'h0032, 16'h0000, 16'h0000);
		wr({`TWEC_OP_SUB_ON, 8'h00});
		wr({`TWEC_OP_TRIG_MODE, 8'h00});
		wr({`TWEC_OP_CONT_MODE, 8'h00});
		repeat (2) @(posedge core_clk);
		ck({14'h0, subtractEn, autoRejectEn}, 16'h0000);
		ck({15'h0, busy}, 16'h0000);
		$display("test trigger settings done");
		apb(`TWEC_HOST_CTRL, 1'b1, 32'h1);
		for (int i = 0; i < 4; i++)
		begin
			set(`TWEC_OP_SET_EDGE, {14'h0, 2'(i)});
			wr({`TWEC_OP_READ_EDGE, 8'h00});
			rdck({14'h0, 2'(i)});
		end
		for (int i = 0; i < 4; i++)
		begin
			set(`TWEC_OP_SET_LSB, {14'h0, 2'(i)});
			wr({`TWEC_OP_READ_RES, 8'h00});
			rdck({14'h0, 2'(i)});
		end
		set(`TWEC_OP_SET_EDGE, 16'h0000);
		set(`TWEC_OP_SET_PAIR, 16'hfefd);
		ck({15'h0, lastErr}, 16'h0000);
		wr({`TWEC_OP_READ_RES, 8'h00});
		rdck(16'h0e05);
		ck({9'h0, pairLeadRes, pairWidthRes}, 16'h005e);
		$display("test edge and resolution done");
		apb(`TWEC_HOST_CTRL, 1'b1, 32'h0);
		set(`TWEC_OP_SET_EDGE, 16'h0000);
		apb(`TWEC_HOST_STATUS, 1'b0, 32'h0);
		ck({14'h0, lastRd[5:4]}, 16'h0001);
		wr({`TWEC_OP_READ_EDGE, 8'h00});
		wr(16'h1000);
		ck({15'h0, lastErr}, 16'h0001);
		rdck(16'h0003);
		apb(`TWEC_HOST_WORD_IN, 1'b0, 32'h0);
		ck({15'h0, lastErr}, 16'h0001);
		apb(8'h10, 1'b0, 32'h0);
		ck({lastRd[14:0], lastErr}, 16'h0001);
		$display("test refusals done");
		report_and_stop();
	end
endmodule : trigger_window_edge_config_opcodes_tb_top
`default_nettype wire
